/* File: logic/wls_sequencer.sv */
// DDR3 write-leveling sequencer: mode entry, strobe pulses, feedback search
`timescale 1ns/1ns
// Function
// - Before the first rising strobe edge the strobe is driven low for at least the low time, never high straight from tri-state.
// - Leveling mode is entered with a mode register set to MR1 before any leveling strobe.
// - Each strobe pulse keeps at least the minimum high and low widths of ordinary writes.
// - Only no-operation or deselect commands go out between the mode command and the strobes.
// - Strobe timing refers to the crossing of the true and complement strobe lines.
// - Incremental leveling intervals set to zero disable periodic re-leveling, automatic leveling stays usable.
module wls_sequencer (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      start,
	input  wire logic                      fbAllLines,
	input  wire logic [wls_pkg::IVL_W-1:0] incrIntervalLvl,
	input  wire logic [wls_pkg::IVL_W-1:0] incrIntervalRamp,
	input  wire logic                      memCk,
	input  wire logic [wls_pkg::DQ_W-1:0]  dqFeedback,
	output wls_pkg::wls_cmd_t              cmd_r,
	output wls_pkg::wls_strobe_t           strobe_r,
	output logic [wls_pkg::DELAY_W-1:0]    levelDelay_r,
	output logic                           busy_r,
	output logic                           done_r,
	output logic                           fail_r,
	output logic                           fbFault_r
);
	import wls_pkg::*;

	wls_state_t         state_r;
	wls_state_t         state_nxt;
	logic [CNT_W-1:0]   cnt_r;
	logic [DELAY_W-1:0] delay_r;
	logic               fbPrev_r;
	logic               ckPrev_r;
	logic [1:0]         ckSettle_r;
	logic               ckSync;
	logic [DQ_W-1:0]    fbSync;
	logic               ckRise;
	logic               fbBit;
	logic               fbOthersHigh;
	logic               found;
	logic               exhausted;
	logic [IVL_W-1:0]   interval;
	logic [IVL_W-1:0]   ivlCnt_r;
	logic               incrKick;
	logic               cntDone;

	// Pin synchronisers
	wls_sync #(.W(1)) ckSyncInst (
		.clk     (clk),
		.resetn  (resetn),
		.asyncIn (memCk),
		.syncOut (ckSync)
	);

	wls_sync #(.W(DQ_W)) fbSyncInst (
		.clk     (clk),
		.resetn  (resetn),
		.asyncIn (dqFeedback),
		.syncOut (fbSync)
	);

	// Memory clock edge finder, held off until the synchroniser has settled
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ckPrev_r   <= 1'b0;
			ckSettle_r <= 2'h0;
		end else begin
			ckPrev_r <= ckSync;
			if (!(&ckSettle_r)) begin
				ckSettle_r <= ckSettle_r + 2'h1;
			end
		end
	end

	assign ckRise = ckSync & ~ckPrev_r & (&ckSettle_r);

	// Feedback decode, prime line or all lines
	always_comb begin
		if (fbAllLines) begin
			fbBit        = &fbSync;
			fbOthersHigh = 1'b0;
		end else begin
			fbBit        = fbSync[0];
			fbOthersHigh = |fbSync[DQ_W-1:1];
		end
	end

	assign found     = fbBit & ~fbPrev_r;
	assign exhausted = (delay_r == DELAY_MAX);
	assign cntDone   = (cnt_r == '0);

	// Incremental interval select, zero disables
	assign interval = (incrIntervalLvl != '0) ? incrIntervalLvl : incrIntervalRamp;
	assign incrKick = (interval != '0) && (ivlCnt_r == interval) && ckRise;

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_MRS_ON;
				end
			end
			ST_MRS_ON: begin
				if (ckRise) begin
					state_nxt = ST_MOD_WAIT;
				end
			end
			ST_MOD_WAIT: begin
				if (cntDone) begin
					state_nxt = ST_PREAMBLE;
				end
			end
			ST_PREAMBLE: begin
				if (cntDone) begin
					state_nxt = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (cntDone) begin
					state_nxt = ST_LOW;
				end
			end
			ST_LOW: begin
				if (cntDone) begin
					state_nxt = ST_FB_WAIT;
				end
			end
			ST_FB_WAIT: begin
				if (cntDone) begin
					state_nxt = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (found || exhausted) begin
					state_nxt = ST_MRS_OFF;
				end else begin
					state_nxt = ST_PREAMBLE;
				end
			end
			ST_MRS_OFF: begin
				if (ckRise) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				if (start || incrKick) begin
					state_nxt = ST_MRS_ON;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Phase counter, loaded on entry to each timed state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (state_r == ST_MRS_ON && ckRise) begin
			cnt_r <= MOD_WAIT_CYC - 8'h01;
		end else if ((state_r == ST_MOD_WAIT && cntDone) ||
				(state_r == ST_SAMPLE && !found && !exhausted)) begin
			cnt_r <= DQS_LOW_CYC - 8'h01 + CNT_W'(delay_r);
		end else if (state_r == ST_PREAMBLE && cntDone) begin
			cnt_r <= DQS_HIGH_CYC - 8'h01;
		end else if (state_r == ST_HIGH && cntDone) begin
			cnt_r <= DQS_LOW_CYC - 8'h01;
		end else if (state_r == ST_LOW && cntDone) begin
			cnt_r <= FB_WAIT_CYC - 8'h01;
		end else if (!cntDone) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	// Command bus
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r <= CMD_DESELECT;
		end else if (ckRise) begin
			if (state_r == ST_MRS_ON || state_r == ST_MRS_OFF) begin
				cmd_r.csN  <= 1'b0;
				cmd_r.rasN <= 1'b0;
				cmd_r.casN <= 1'b0;
				cmd_r.weN  <= 1'b0;
				cmd_r.ba   <= BA_MR1;
				cmd_r.addr <= MR1_BASE;
				cmd_r.addr[MR1_WL_BIT] <= (state_r == ST_MRS_ON);
			end else if (state_r == ST_IDLE || state_r == ST_DONE) begin
				cmd_r <= CMD_DESELECT;
			end else begin
				cmd_r <= CMD_NOP;
			end
		end
	end

	// Differential strobe, both lines from one flop stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strobe_r <= STROBE_RST;
		end else begin
			case (state_nxt)
				ST_PREAMBLE, ST_LOW, ST_FB_WAIT, ST_SAMPLE: begin
					strobe_r.oe   <= 1'b1;
					strobe_r.dqs  <= 1'b0;
					strobe_r.dqsN <= 1'b1;
				end
				ST_HIGH: begin
					strobe_r.oe   <= 1'b1;
					strobe_r.dqs  <= 1'b1;
					strobe_r.dqsN <= 1'b0;
				end
				default: begin
					strobe_r <= STROBE_RST;
				end
			endcase
		end
	end

	// Delay search and result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			delay_r      <= DELAY_RST;
			fbPrev_r     <= 1'b0;
			levelDelay_r <= DELAY_RST;
			fail_r       <= 1'b0;
		end else if (state_r == ST_MRS_ON) begin
			delay_r  <= DELAY_RST;
			fbPrev_r <= 1'b1;
		end else if (state_r == ST_SAMPLE) begin
			fbPrev_r <= fbBit;
			if (found) begin
				levelDelay_r <= delay_r;
				fail_r       <= 1'b0;
			end else if (exhausted) begin
				fail_r <= 1'b1;
			end else begin
				delay_r <= delay_r + 6'h01;
			end
		end
	end

	// Unused feedback lines seen high during a run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fbFault_r <= 1'b0;
		end else if (state_r == ST_MRS_ON) begin
			fbFault_r <= 1'b0;
		end else if (state_r == ST_SAMPLE && fbOthersHigh) begin
			fbFault_r <= 1'b1;
		end
	end

	// Periodic incremental re-leveling counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ivlCnt_r <= '0;
		end else if (state_r != ST_DONE || interval == '0) begin
			ivlCnt_r <= '0;
		end else if (ckRise && ivlCnt_r != interval) begin
			ivlCnt_r <= ivlCnt_r + 8'h01;
		end
	end

	// Status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			busy_r <= (state_nxt != ST_IDLE) && (state_nxt != ST_DONE);
			done_r <= (state_nxt == ST_DONE);
		end
	end

endmodule : wls_sequencer

/* File: include/wls_pkg.sv */
// Shared constants and types for the write-leveling sequencer
package wls_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int DQS_HIGH_MIN_NS = 40;
	localparam int DQS_LOW_MIN_NS  = 40;
	localparam int MOD_WAIT_NS     = 480;
	localparam int FB_WAIT_NS      = 360;
	localparam int CNT_W           = 8;

	localparam logic [CNT_W-1:0] DQS_HIGH_CYC =
		CNT_W'((DQS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] DQS_LOW_CYC =
		CNT_W'((DQS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] MOD_WAIT_CYC =
		CNT_W'((MOD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FB_WAIT_CYC =
		CNT_W'((FB_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Widths
	localparam int DQ_W    = 8;
	localparam int ADDR_W  = 14;
	localparam int BA_W    = 3;
	localparam int DELAY_W = 6;
	localparam int IVL_W   = 8;

	// Leveling delay range
	localparam logic [DELAY_W-1:0] DELAY_MAX  = 6'h3F;
	localparam logic [DELAY_W-1:0] DELAY_RST  = 6'h00;

	// Mode register 1 select and leveling enable bit position
	localparam logic [BA_W-1:0]   BA_MR1      = 3'h1;
	localparam int                MR1_WL_BIT  = 7;
	localparam logic [ADDR_W-1:0] MR1_BASE    = 14'h0000;

	// Command bus word
	typedef struct packed {
		logic              csN;
		logic              rasN;
		logic              casN;
		logic              weN;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
	} wls_cmd_t;

	localparam wls_cmd_t CMD_NOP = '{csN: 1'b0, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
		ba: 3'h0, addr: 14'h0000};
	localparam wls_cmd_t CMD_DESELECT = '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
		ba: 3'h0, addr: 14'h0000};

	// Strobe pin group
	typedef struct packed {
		logic dqs;
		logic dqsN;
		logic oe;
	} wls_strobe_t;

	localparam wls_strobe_t STROBE_RST = '{dqs: 1'b0, dqsN: 1'b1, oe: 1'b0};

	// Sequencer states, one-hot
	typedef enum logic [9:0] {
		ST_IDLE     = 10'h001,
		ST_MRS_ON   = 10'h002,
		ST_MOD_WAIT = 10'h004,
		ST_PREAMBLE = 10'h008,
		ST_HIGH     = 10'h010,
		ST_LOW      = 10'h020,
		ST_FB_WAIT  = 10'h040,
		ST_SAMPLE   = 10'h080,
		ST_MRS_OFF  = 10'h100,
		ST_DONE     = 10'h200
	} wls_state_t;

endpackage : wls_pkg

/* File: logic/wls_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module wls_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] stage1_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1_r <= '0;
			syncOut  <= '0;
		end else begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end

endmodule : wls_sync

/* File: verification/wls_sequencer_chk.sv */
// Assertion checker for the write-leveling sequencer
`timescale 1ns/1ns
module wls_sequencer_chk (
	input wire logic                        clk,
	input wire logic                        resetn,
	input wire logic                        start,
	input wire logic [wls_pkg::IVL_W-1:0]   incrIntervalLvl,
	input wire logic [wls_pkg::IVL_W-1:0]   incrIntervalRamp,
	input wire wls_pkg::wls_cmd_t           cmd_r,
	input wire wls_pkg::wls_strobe_t        strobe_r,
	input wire logic [wls_pkg::DELAY_W-1:0] levelDelay_r,
	input wire logic                        busy_r,
	input wire logic                        done_r
);
	import wls_pkg::*;
	logic isMrs;
	logic lvlSeen_r;
	assign isMrs = !cmd_r.csN && !cmd_r.rasN && !cmd_r.casN && !cmd_r.weN && cmd_r.ba == BA_MR1;
	// Leveling mode as last loaded
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) lvlSeen_r <= 1'b0;
		else if (isMrs) lvlSeen_r <= cmd_r.addr[MR1_WL_BIT];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence sPulse;
		strobe_r.dqs ##1 !strobe_r.dqs;
	endsequence
	sequence sLowRun;
		!strobe_r.dqs [*8];
	endsequence
	sequence sDoneHeld;
		done_r ##1 done_r;
	endsequence
	AST_STROBE_PAIR: assert property (strobe_r.oe |-> strobe_r.dqsN != strobe_r.dqs)
		else $error("strobe pair not complementary");
	AST_PREAMBLE: assert property ($rose(strobe_r.dqs) |-> $past(strobe_r.oe) && strobe_r.oe)
		else $error("strobe rose without low preamble");
	AST_HIGH_WIDTH: assert property ($rose(strobe_r.dqs) |-> sPulse)
		else $error("strobe high width wrong");
	AST_LOW_WIDTH: assert property ($fell(strobe_r.dqs) && strobe_r.oe |=> sLowRun)
		else $error("strobe low width too short");
	AST_MRS_FIRST: assert property ($rose(strobe_r.oe) |-> lvlSeen_r)
		else $error("strobe before leveling mode load");
	AST_NOP_ONLY: assert property (lvlSeen_r && !isMrs |-> cmd_r == CMD_NOP || cmd_r == CMD_DESELECT)
		else $error("command other than no-op during leveling");
	AST_NO_INCR: assert property (done_r && !start && incrIntervalLvl == '0
		&& incrIntervalRamp == '0 |=> !busy_r)
		else $error("restart with intervals at zero");
	AST_DELAY_HOLD: assert property (sDoneHeld |-> $stable(levelDelay_r))
		else $error("recorded delay moved while done");
endmodule : wls_sequencer_chk

bind wls_sequencer wls_sequencer_chk chk (.clk, .resetn, .start, .incrIntervalLvl,
	.incrIntervalRamp, .cmd_r, .strobe_r, .levelDelay_r, .busy_r, .done_r);

/* File: verification/wls_dram_model.sv */
// Behavioural DDR3 device answering leveling strobes
`timescale 1ns/1ns
module wls_dram_model (
	input wire logic                     memCk,
	input wire wls_pkg::wls_cmd_t        cmd,
	input wire wls_pkg::wls_strobe_t     strobe,
	input wire logic                     allLines,
	input wire logic [6:0]               thresh,
	input wire logic                     fault,
	output logic [wls_pkg::DQ_W-1:0]     dq
);
	import wls_pkg::*;
	logic lvlMode = 1'b0;
	logic tgl = 1'b0;
	logic [6:0] cnt = 7'h00;
	logic fb;
	// Mode entry and exit on MR1 loads
	always @(posedge memCk) begin
		tgl <= ~tgl;
		if (!cmd.csN && !cmd.rasN && !cmd.casN && !cmd.weN && cmd.ba == BA_MR1) begin
			lvlMode <= cmd.addr[MR1_WL_BIT];
		end
	end
	// Strobe rises counted against a fixed flight delay
	always @(posedge strobe.dqs or negedge strobe.oe) begin
		if (!strobe.oe) cnt <= 7'h00;
		else if (cnt != 7'h7F) cnt <= cnt + 7'h01;
	end
	assign fb = cnt > thresh;
	always_comb begin
		if (!lvlMode) dq = {DQ_W{tgl}};
		else if (allLines) dq = {DQ_W{fb}};
		else dq = {{(DQ_W-1){fault}}, fb};
	end
endmodule : wls_dram_model

/* File: verification/wls_sequencer_test.sv */
// Self-checking bench for the write-leveling sequencer
`timescale 1ns/1ns
module wls_sequencer_test;
	import wls_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0;
	logic allLines = 1'b0;
	logic memCk = 1'b0;
	logic fault = 1'b0;
	logic [IVL_W-1:0] ivlLvl = '0;
	logic [IVL_W-1:0] ivlRamp = '0;
	logic [6:0] thresh = 7'h00;
	logic [DQ_W-1:0] dq;
	wls_cmd_t cmd;
	wls_strobe_t strobe;
	logic [DELAY_W-1:0] delay;
	logic busy, done, fail, fbFault;
	int err_count = 0;
	int comparisons = 0;
	wls_sequencer uut (.clk(clk), .resetn(resetn), .start(start), .fbAllLines(allLines),
		.incrIntervalLvl(ivlLvl), .incrIntervalRamp(ivlRamp), .memCk(memCk),
		.dqFeedback(dq), .cmd_r(cmd), .strobe_r(strobe), .levelDelay_r(delay),
		.busy_r(busy), .done_r(done), .fail_r(fail), .fbFault_r(fbFault));
	wls_dram_model dram (.memCk(memCk), .cmd(cmd), .strobe(strobe), .allLines(allLines),
		.thresh(thresh), .fault(fault), .dq(dq));
	initial begin
		forever #20 clk = ~clk;
	end
	initial begin
		#7;
		forever #160 memCk = ~memCk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic wait_for(input logic busyLevel);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while ((busyLevel ? busy : done) !== 1'b1 && n < 6000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("level", 1'h1, busyLevel ? busy : done);
	endtask : wait_for
	task automatic run(input logic all, input logic [6:0] th, input logic flt);
		@(posedge clk);
		allLines <= all;
		thresh <= th;
		fault <= flt;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		wait_for(1'b0);
	endtask : run
	task automatic t_prime();
		run(1'b0, 7'h05, 1'b0);
		chk("done", 1'h1, done);
		chk("delay", 6'h05, delay);
		chk("fail", 1'h0, fail);
		chk("fbFault", 1'h0, fbFault);
		repeat (40) @(posedge clk);
		chk("busy", 1'h0, busy);
		chk("cmd", CMD_DESELECT, cmd);
	endtask : t_prime
	task automatic t_edges();
		run(1'b1, 7'h00, 1'b0);
		chk("fail", 1'h1, fail);
		run(1'b0, 7'h01, 1'b0);
		chk("delay", 6'h01, delay);
		run(1'b1, 7'h1E, 1'b0);
		chk("delay", 6'h1E, delay);
		chk("fail", 1'h0, fail);
		run(1'b0, 7'h0A, 1'b1);
		chk("delay", 6'h0A, delay);
		chk("fbFault", 1'h1, fbFault);
	endtask : t_edges
	task automatic t_incr();
		run(1'b0, 7'h03, 1'b0);
		@(posedge clk);
		ivlLvl <= 8'h02;
		wait_for(1'b1);
		chk("busy", 1'h1, busy);
		@(posedge clk);
		ivlLvl <= 8'h00;
		ivlRamp <= 8'h03;
		wait_for(1'b0);
		wait_for(1'b1);
		chk("busy", 1'h1, busy);
		@(posedge clk);
		ivlRamp <= 8'h00;
		wait_for(1'b0);
		repeat (40) @(posedge clk);
		chk("busy", 1'h0, busy);
	endtask : t_incr
	task automatic t_reset_mid();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (60) @(posedge clk);
		resetn <= 1'b0;
		#1;
		chk("cmd", CMD_DESELECT, cmd);
		chk("oe", 1'h0, strobe.oe);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		run(1'b0, 7'h02, 1'b0);
		chk("delay", 6'h02, delay);
	endtask : t_reset_mid
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_prime();
		t_edges();
		t_incr();
		t_reset_mid();
		end_sim();
	end
	initial begin
		#(40 * 60000);
		err_count++;
		end_sim();
	end
endmodule : wls_sequencer_test
